// File: include/vhz_defs.vh
// vhz_defs.vh: constants for the drive start/stop sequencer and its helpers
// assumes: 100 MHz system clock, frequencies in 0.1 Hz units, voltage and boost in 0.01 % units
`ifndef VHZ_DEFS_VH
`define VHZ_DEFS_VH

// ==========================================================
// clock and timing
`define VHZ_CLK_HZ 100000000
`define VHZ_MS_CYCLES (`VHZ_CLK_HZ / 1000)
`define VHZ_HOLDOFF_MS 200
`define VHZ_POWER_SETTLE_MS 2000
`define VHZ_BRAKE_S 15
`define VHZ_LOW_FAULT_DELAY_S 30
`define VHZ_DECAY_MIN 15
`define VHZ_SYNC_LOW_MS 16'd6000
`define VHZ_SYNC_FAST_MS 16'd1000
`define VHZ_BRAKE_MS 16'd15000
`define VHZ_LOW_FAULT_DELAY_MS 16'd30000
// one tick more than the hold-off: the first tick may land right after the load
`define VHZ_HOLDOFF_TICKS 16'd201

// ==========================================================
// curve and carrier figures: output frequencies in 0.1 Hz, VHZ_VARC_FIXED_HZ in Hz, VHZ_FULL_VOLT in 0.01 %
`define VHZ_BOOST_END_DHZ 16'd300
`define VHZ_VARC_KNEE_DHZ 16'd250
`define VHZ_LOW_FAULT_DHZ 16'd15
`define VHZ_VARC_FIXED_HZ 16'd1500
`define VHZ_VARC_RATIO 16'd6
`define VHZ_FULL_VOLT 16'd10000

// ==========================================================
// selections
`define VHZ_CURVE_CONST 2'd0
`define VHZ_CURVE_VAR 2'd1
`define VHZ_CURVE_CT_NC 2'd2
`define VHZ_START_NORMAL 3'd0
`define VHZ_START_POWERUP 3'd1
`define VHZ_START_FLY_LOW 3'd2
`define VHZ_START_FLY_MED 3'd3
`define VHZ_START_FLY_HIGH 3'd4
`define VHZ_STOP_COAST 2'd0
`define VHZ_STOP_RAMP 2'd1
`define VHZ_STOP_RAMP_NOHOLD 2'd2
`define VHZ_FAULT_OUTPUT 2'd0
`define VHZ_FAULT_CONTROL 2'd1
`define VHZ_FAULT_SUPPLY_DIP 2'd2
`define VHZ_FAULT_OTHER 2'd3
`define VHZ_MAX_RESTARTS 3'd5
`define VHZ_SEARCH_RESTARTS 3'd2

`endif

// File: hw/vhz_curve.v
// vhz_curve.v: volts-per-hertz shaping with low-speed lift
// assumes: base frequency nonzero; output in 0.01 % of rated voltage
`default_nettype none
`include "vhz_defs.vh"

module vhz_curve (
  // setting
  input wire [15:0] freq_in,
  input wire [15:0] base_freq_in,
  input wire [15:0] lift_in,
  input wire [1:0] curve_sel_in,
  // result
  output wire [15:0] volt_out
);
  wire [15:0] f_clip;
  wire [31:0] lin;
  wire [31:0] quad;
  wire [31:0] shaped;
  wire [31:0] lift_part;
  wire [31:0] sum;

  assign f_clip = (freq_in >= base_freq_in) ? base_freq_in : freq_in;
  assign lin = ({16'h0000, f_clip} * {16'h0000, `VHZ_FULL_VOLT}) / {16'h0000, base_freq_in};
  // variable curve bends voltage with the square of frequency to save energy
  assign quad = (lin * {16'h0000, f_clip}) / {16'h0000, base_freq_in};
  assign shaped = (curve_sel_in == `VHZ_CURVE_VAR) ? quad : lin;
  assign lift_part = (freq_in >= `VHZ_BOOST_END_DHZ) ? 32'h0000_0000 :
    ({16'h0000, lift_in} * {16'h0000, `VHZ_BOOST_END_DHZ - freq_in}) / {16'h0000, `VHZ_BOOST_END_DHZ};
  assign sum = shaped + lift_part;
  assign volt_out = (sum > {16'h0000, `VHZ_FULL_VOLT}) ? `VHZ_FULL_VOLT : sum[15:0];
endmodule // vhz_curve

`default_nettype wire

// File: hw/vhz_carrier.v
// vhz_carrier.v: switching carrier choice from the selection and output frequency
// assumes: frequency in 0.1 Hz; carrier result in Hz
`default_nettype none
`include "vhz_defs.vh"

module vhz_carrier (
  // setting
  input wire [2:0] carrier_sel_in,
  input wire [15:0] freq_in,
  // result
  output reg [15:0] carrier_hz_out
);
  always @* begin
    case (carrier_sel_in)
      3'd0: begin
        // 0.1 Hz units times 6 gives a ratio of 60 per Hz
        if (freq_in <= `VHZ_VARC_KNEE_DHZ) carrier_hz_out = `VHZ_VARC_FIXED_HZ;
        else carrier_hz_out = freq_in * `VHZ_VARC_RATIO;
      end
      3'd1: carrier_hz_out = 16'd6000;
      3'd2: carrier_hz_out = 16'd8000;
      3'd3: carrier_hz_out = 16'd10000;
      3'd4: carrier_hz_out = 16'd12000;
      3'd5: carrier_hz_out = 16'd14000;
      default: carrier_hz_out = 16'd6000;
    endcase
  end
endmodule // vhz_carrier

`default_nettype wire

// File: hw/vhz_sequencer.v
// vhz_sequencer.v: start/stop sequencer for a volts-per-hertz drive
// assumes: inputs synchronous to sys_clk_in; the ramp generator outside follows ramp_down_out
// Operation
// - voltage rises with frequency, full voltage exactly at base frequency
// - above base frequency voltage is held while frequency rises
// - low-speed lift added at zero, tapering to nothing by 30 Hz
// - lift default comes from the horsepower rating, 5.30 % down to 0.80 %
// - curve select picks constant or variable volts-per-hertz, three choices
// - uncompensated constant torque disables low-speed overload derating
// - six carrier choices, all but the lowest constant over speed
// - variable carrier fixed at 1.5 kHz up to 25 Hz
// - above 25 Hz variable carrier is output frequency times 60
// - power-up mode starts by itself with two-wire start held
// - flying restarts sync in 6 s at 50 %, 1 s at 50 %, 1 s at 100 %
// - flying restarts act only under remote control; a start held since power-on runs in any mode
// - up to five restarts, then a lockout cleared by manual reset
// - waiting indication shown between automatic restart attempts
// - attempt counter drops by one every 15 minutes
// - first two restarts search speed, others brake 15 s then start
// - no automatic restart after control or supply dip fault
// - output fault below 1.5 Hz: one retry after 30 s, then lockout
// - coast stop switches output off at once
// - ramp stop decelerates, then blocks start for 200 ms at zero
// - ramp without hold allows immediate restart
`default_nettype none
`include "vhz_defs.vh"

module vhz_sequencer #(
  parameter [31:0] MS_CYCLES = `VHZ_MS_CYCLES
) (
  // clock and reset
  input wire sys_clk_in,
  input wire arst_n_in,
  // settings
  input wire [15:0] base_freq_in,
  input wire [3:0] hp_code_in,
  input wire lift_override_in,
  input wire [15:0] lift_set_in,
  input wire [1:0] curve_sel_in,
  input wire [2:0] carrier_sel_in,
  input wire [2:0] start_mode_in,
  input wire [1:0] stop_mode_in,
  input wire remote_in,
  // operator and drive state
  input wire start_cmd_in,
  input wire manual_reset_in,
  input wire [15:0] out_freq_in,
  input wire fault_in,
  input wire [1:0] fault_kind_in,
  // outputs
  output reg run_out,
  output reg ramp_down_out,
  output reg search_out,
  output reg [6:0] search_current_pct_out,
  output reg [15:0] search_ms_out,
  output reg dc_brake_out,
  output reg restart_waiting_indication_out,
  output reg restart_exhausted_trip_out,
  output reg overload_derate_en_out,
  output reg [2:0] restarts_left_out,
  output reg [15:0] volt_out,
  output reg [15:0] carrier_hz_out
);
  // ==========================================================
  // states
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_RUN = 3'd1;
  localparam [2:0] S_RAMP = 3'd2;
  localparam [2:0] S_HOLD = 3'd3;
  localparam [2:0] S_WAIT = 3'd4;
  localparam [2:0] S_BRAKE = 3'd5;
  localparam [2:0] S_TRIP = 3'd6;
  localparam [2:0] S_FAULT = 3'd7;

  // ==========================================================
  // lift default by horsepower step
  function [15:0] lift_default;
    input [3:0] hp;
    begin
      case (hp)
        4'd0: lift_default = 16'd530;
        4'd1: lift_default = 16'd440;
        4'd2: lift_default = 16'd360;
        4'd3: lift_default = 16'd300;
        4'd4: lift_default = 16'd270;
        4'd5: lift_default = 16'd240;
        4'd6: lift_default = 16'd220;
        4'd7: lift_default = 16'd200;
        4'd8: lift_default = 16'd180;
        4'd9: lift_default = 16'd160;
        4'd10: lift_default = 16'd120;
        default: lift_default = 16'd80;
      endcase
    end
  endfunction

  function is_flying;
    input [2:0] m;
    begin
      is_flying = (m == `VHZ_START_FLY_LOW) || (m == `VHZ_START_FLY_MED) || (m == `VHZ_START_FLY_HIGH);
    end
  endfunction

  // ==========================================================
  // millisecond tick
  reg [31:0] div_reg;
  reg ms_tick_reg;
  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      div_reg <= 32'h0000_0000;
      ms_tick_reg <= 1'b0;
    end else if (div_reg >= MS_CYCLES - 32'h1) begin
      div_reg <= 32'h0000_0000;
      ms_tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 32'h1;
      ms_tick_reg <= 1'b0;
    end
  end

  // ==========================================================
  // power-up settle: starts ignored for two seconds
  reg [11:0] pwr_ms_reg;
  wire pwr_ok;
  assign pwr_ok = (pwr_ms_reg >= `VHZ_POWER_SETTLE_MS);
  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) pwr_ms_reg <= 12'h000;
    else if (ms_tick_reg && !pwr_ok) pwr_ms_reg <= pwr_ms_reg + 12'h001;
  end

  // ==========================================================
  // curve and carrier
  wire [15:0] lift_val;
  wire [15:0] volt_w;
  wire [15:0] carrier_w;
  assign lift_val = lift_override_in ? lift_set_in : lift_default(hp_code_in);

  vhz_curve u_curve (
    .freq_in(out_freq_in),
    .base_freq_in(base_freq_in),
    .lift_in(lift_val),
    .curve_sel_in(curve_sel_in),
    .volt_out(volt_w)
  );

  vhz_carrier u_carrier (
    .carrier_sel_in(carrier_sel_in),
    .freq_in(out_freq_in),
    .carrier_hz_out(carrier_w)
  );

  // ==========================================================
  // sequencer
  reg [2:0] state_reg;
  reg [2:0] used_reg;
  reg [19:0] decay_ms_reg;
  reg [15:0] wait_ms_reg;
  reg low_fault_reg;
  reg first_start_reg;
  wire auto_ok;
  wire search_now;
  assign auto_ok = remote_in && is_flying(start_mode_in);
  assign search_now = (used_reg < `VHZ_SEARCH_RESTARTS);

  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= S_IDLE;
      used_reg <= 3'd0;
      decay_ms_reg <= 20'h00000;
      wait_ms_reg <= 16'h0000;
      low_fault_reg <= 1'b0;
      first_start_reg <= 1'b1;
      run_out <= 1'b0;
      ramp_down_out <= 1'b0;
      search_out <= 1'b0;
      dc_brake_out <= 1'b0;
    end else begin
      // restart credit returns every 15 minutes, never below zero used
      if (ms_tick_reg && used_reg != 3'd0) begin
        if (decay_ms_reg >= (`VHZ_DECAY_MIN * 60000 - 1)) begin
          decay_ms_reg <= 20'h00000;
          used_reg <= used_reg - 3'd1;
        end else begin
          decay_ms_reg <= decay_ms_reg + 20'h00001;
        end
      end else if (used_reg == 3'd0) begin
        decay_ms_reg <= 20'h00000;
      end
      if (ms_tick_reg && wait_ms_reg != 16'h0000) wait_ms_reg <= wait_ms_reg - 16'h0001;
      if (ms_tick_reg && search_out && wait_ms_reg == 16'h0001) search_out <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (pwr_ok && start_cmd_in) begin
            // under remote control, power-up and flying modes catch a start held since power-on here; every other start runs through the next branch
            if (first_start_reg && remote_in && start_mode_in != `VHZ_START_NORMAL) begin
              state_reg <= S_RUN;
              run_out <= 1'b1;
            end else if (!first_start_reg || start_mode_in == `VHZ_START_NORMAL || !remote_in) begin
              state_reg <= S_RUN;
              run_out <= 1'b1;
            end
            first_start_reg <= 1'b0;
          end else if (pwr_ok) begin
            first_start_reg <= 1'b0;
          end
        end
        S_RUN: begin
          if (fault_in) begin
            run_out <= 1'b0;
            search_out <= 1'b0;
            if (!auto_ok || fault_kind_in == `VHZ_FAULT_CONTROL || fault_kind_in == `VHZ_FAULT_SUPPLY_DIP) begin
              state_reg <= S_FAULT;
            end else if (low_fault_reg || used_reg >= `VHZ_MAX_RESTARTS) begin
              state_reg <= S_TRIP;
            end else if (fault_kind_in == `VHZ_FAULT_OUTPUT && out_freq_in < `VHZ_LOW_FAULT_DHZ) begin
              low_fault_reg <= 1'b1;
              wait_ms_reg <= `VHZ_LOW_FAULT_DELAY_MS;
              state_reg <= S_WAIT;
            end else begin
              wait_ms_reg <= 16'd1000;
              state_reg <= S_WAIT;
            end
          end else if (!start_cmd_in) begin
            if (stop_mode_in == `VHZ_STOP_COAST) begin
              run_out <= 1'b0;
              state_reg <= S_IDLE;
            end else begin
              ramp_down_out <= 1'b1;
              state_reg <= S_RAMP;
            end
          end else if (!fault_in && used_reg == 3'd0) begin
            low_fault_reg <= 1'b0;
          end
        end
        S_RAMP: begin
          if (out_freq_in == 16'h0000) begin
            ramp_down_out <= 1'b0;
            run_out <= 1'b0;
            if (stop_mode_in == `VHZ_STOP_RAMP) begin
              wait_ms_reg <= `VHZ_HOLDOFF_TICKS;
              state_reg <= S_HOLD;
            end else begin
              state_reg <= S_IDLE;
            end
          end else if (start_cmd_in) begin
            ramp_down_out <= 1'b0;
            state_reg <= S_RUN;
          end
        end
        S_HOLD: begin
          if (wait_ms_reg == 16'h0000) state_reg <= S_IDLE;
        end
        S_WAIT: begin
          if (wait_ms_reg == 16'h0000 && start_cmd_in) begin
            used_reg <= used_reg + 3'd1;
            if (search_now) begin
              search_out <= 1'b1;
              wait_ms_reg <= (start_mode_in == `VHZ_START_FLY_LOW) ? `VHZ_SYNC_LOW_MS : `VHZ_SYNC_FAST_MS;
              run_out <= 1'b1;
              state_reg <= S_RUN;
            end else begin
              dc_brake_out <= 1'b1;
              wait_ms_reg <= `VHZ_BRAKE_MS;
              state_reg <= S_BRAKE;
            end
          end
        end
        S_BRAKE: begin
          if (wait_ms_reg == 16'h0000) begin
            dc_brake_out <= 1'b0;
            run_out <= 1'b1;
            state_reg <= S_RUN;
          end
        end
        S_TRIP: begin
          if (manual_reset_in) begin
            used_reg <= 3'd0;
            low_fault_reg <= 1'b0;
            state_reg <= S_IDLE;
          end
        end
        S_FAULT: begin
          if (manual_reset_in) state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // registered status and analog settings
  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      restart_waiting_indication_out <= 1'b0;
      restart_exhausted_trip_out <= 1'b0;
      overload_derate_en_out <= 1'b1;
      restarts_left_out <= `VHZ_MAX_RESTARTS;
      search_current_pct_out <= 7'd50;
      search_ms_out <= 16'h0000;
      volt_out <= 16'h0000;
      carrier_hz_out <= 16'h0000;
    end else begin
      restart_waiting_indication_out <= (state_reg == S_WAIT) || (state_reg == S_BRAKE);
      restart_exhausted_trip_out <= (state_reg == S_TRIP);
      overload_derate_en_out <= (curve_sel_in != `VHZ_CURVE_CT_NC);
      restarts_left_out <= `VHZ_MAX_RESTARTS - used_reg;
      search_current_pct_out <= (start_mode_in == `VHZ_START_FLY_HIGH) ? 7'd100 : 7'd50;
      search_ms_out <= (start_mode_in == `VHZ_START_FLY_LOW) ? `VHZ_SYNC_LOW_MS : `VHZ_SYNC_FAST_MS;
      volt_out <= run_out ? volt_w : 16'h0000;
      carrier_hz_out <= carrier_w;
    end
  end
endmodule // vhz_sequencer

`default_nettype wire

// File: verif/vhz_seq_monitor.sv
// vhz_seq_monitor.sv: port-level assertions for the start/stop sequencer
// assumes: bound to vhz_sequencer, one clock, async active-low reset
`default_nettype none
`include "vhz_defs.vh"

module vhz_seq_monitor #(
  parameter [31:0] MS_CYCLES = 32'd10
) (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // inputs watched
  input wire logic [2:0] carrier_sel_in,
  input wire logic [1:0] curve_sel_in,
  input wire logic [1:0] stop_mode_in,
  input wire logic start_cmd_in,
  input wire logic manual_reset_in,
  input wire logic [15:0] out_freq_in,
  input wire logic fault_in,
  input wire logic [1:0] fault_kind_in,
  // outputs watched
  input wire logic run_out,
  input wire logic search_out,
  input wire logic restart_waiting_indication_out,
  input wire logic restart_exhausted_trip_out,
  input wire logic overload_derate_en_out,
  input wire logic [2:0] restarts_left_out,
  input wire logic [15:0] volt_out,
  input wire logic [15:0] carrier_hz_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  // ==========================================================
  // ramp hold-off tracker
  // two cycles of slack: where the design starts its own count is its choice
  logic [31:0] hold_cnt_reg;
  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hold_cnt_reg <= 32'h0;
    end else if ($fell(run_out) && stop_mode_in == `VHZ_STOP_RAMP) begin
      hold_cnt_reg <= MS_CYCLES * 32'd200 - 32'd2;
    end else if (hold_cnt_reg != 32'h0) begin
      hold_cnt_reg <= hold_cnt_reg - 32'h1;
    end
  end

  // ==========================================================
  // assertions
  AST_VOLT_IDLE: assert property (!run_out && !$past(run_out) |-> volt_out == 16'h0)
    else $error("volt_out nonzero while stopped");
  AST_CARR_LOW: assert property ((carrier_sel_in == 3'h0 && out_freq_in <= 16'h00fa)[*3] |-> carrier_hz_out == 16'h05dc)
    else $error("variable carrier not 1500 Hz at low speed");
  AST_CARR_HIGH: assert property ((carrier_sel_in == 3'h0 && out_freq_in > 16'h00fa && $stable(out_freq_in))[*3]
    |-> carrier_hz_out == out_freq_in * 16'h0006)
    else $error("variable carrier not 60 times output frequency");
  AST_CARR_FIXED: assert property ((carrier_sel_in inside {[3'h1:3'h5]} && $stable(carrier_sel_in))[*3]
    |-> carrier_hz_out == 16'h0fa0 + 16'h07d0 * carrier_sel_in)
    else $error("fixed carrier wrong");
  AST_DERATE_OFF: assert property ((curve_sel_in == `VHZ_CURVE_CT_NC)[*3] |-> !overload_derate_en_out)
    else $error("derating left on in uncompensated curve");
  AST_RUN_CAUSE: assert property ($rose(run_out) |-> $past(start_cmd_in))
    else $error("run began without a start command");
  AST_COAST: assert property (run_out && stop_mode_in == `VHZ_STOP_COAST && !start_cmd_in |=> !run_out)
    else $error("coast stop did not cut output");
  AST_HOLD: assert property (hold_cnt_reg != 32'h0 |-> !run_out)
    else $error("restart inside ramp hold-off");
  AST_NO_AUTO: assert property (run_out && fault_in && fault_kind_in == `VHZ_FAULT_CONTROL
    |-> ##2 (!restart_waiting_indication_out && !search_out)[*8])
    else $error("automatic restart after control fault");
  AST_TRIP_KEEP: assert property (restart_exhausted_trip_out && !manual_reset_in |=> restart_exhausted_trip_out)
    else $error("lockout cleared without manual reset");
  AST_LEFT_MAX: assert property (restarts_left_out <= 3'h5)
    else $error("restart count above five");

  // ==========================================================
  // main scenarios seen
  cover property ($rose(search_out));
  cover property ($fell(run_out) && stop_mode_in == `VHZ_STOP_RAMP);
  cover property ($rose(restart_waiting_indication_out));
endmodule // vhz_seq_monitor

bind vhz_sequencer vhz_seq_monitor #(.MS_CYCLES(MS_CYCLES)) vhz_seq_monitor_i (.*);
`default_nettype wire

// File: verif/vhz_motor_model.sv
// vhz_motor_model.sv: motor and outside ramp generator, reports output frequency
// assumes: one step of 0.1 Hz per clock, frequency zero whenever output is off
`default_nettype none

module vhz_motor_model (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // from the drive
  input wire logic run_in,
  input wire logic ramp_down_in,
  input wire logic [15:0] target_in,
  // to the drive
  output wire logic [15:0] freq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] freq_reg;
  assign freq_out = freq_reg;
  always @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      freq_reg <= 16'h0;
    end else if (!run_in) begin
      freq_reg <= 16'h0;
    end else if (ramp_down_in) begin
      freq_reg <= (freq_reg == 16'h0) ? 16'h0 : freq_reg - 16'h1;
    end else if (freq_reg < target_in) begin
      freq_reg <= freq_reg + 16'h1;
    end else if (freq_reg > target_in) begin
      freq_reg <= freq_reg - 16'h1;
    end
  end
endmodule // vhz_motor_model
`default_nettype wire

// File: verif/tb_vhz_sequencer.sv
// tb_vhz_sequencer.sv: self-checking bench for the start/stop sequencer
// assumes: MS_CYCLES shrunk to 10, so one ms is ten clocks
`default_nettype none
`include "vhz_defs.vh"

module tb_vhz_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] MSC = 32'd10;
  logic sys_clk_in, arst_n_in, lift_override_in, remote_in, start_cmd_in, manual_reset_in, fault_in;
  logic [15:0] base_freq_in, lift_set_in, out_freq_in, target, volt_out, carrier_hz_out, search_ms_out;
  logic [3:0] hp_code_in;
  logic [1:0] curve_sel_in, stop_mode_in, fault_kind_in;
  logic [2:0] carrier_sel_in, start_mode_in, restarts_left_out;
  logic run_out, ramp_down_out, search_out, dc_brake_out, restart_waiting_indication_out;
  logic restart_exhausted_trip_out, overload_derate_en_out;
  logic [6:0] search_current_pct_out;
  int failures = 0;
  int num_checks = 0;
  int n;

  vhz_sequencer #(.MS_CYCLES(MSC)) vhz_sequencer_i (.*);
  vhz_motor_model vhz_motor_model_i (.sys_clk_in, .arst_n_in, .run_in(run_out), .ramp_down_in(ramp_down_out),
    .target_in(target), .freq_out(out_freq_in));

  // ==========================================================
  // helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    #1;
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic probe(input int s);
    case (s)
      0: return run_out;
      1: return search_out;
      2: return restart_waiting_indication_out;
      default: return out_freq_in == target;
    endcase
  endfunction

  // counts clocks until the probed output reaches v, bounded by lim
  task automatic wait_for(input int s, input logic v, input int lim);
    n = 0;
    // let stimulus given just before the call settle first
    @(posedge sys_clk_in);
    #1;
    while (probe(s) !== v && n < lim) begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end
  endtask

  task automatic pulse_fault(input logic [1:0] kind);
    @(posedge sys_clk_in);
    fault_in <= 1'b1;
    fault_kind_in <= kind;
    @(posedge sys_clk_in);
    fault_in <= 1'b0;
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================================
  // clock and watchdog
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  initial begin
    repeat (95000) @(posedge sys_clk_in);
    failures++;
    report_and_stop();
  end

  // ==========================================================
  // tests
  initial begin
    arst_n_in = 1'b0;
    base_freq_in = 16'd600;
    hp_code_in = 4'h0;
    lift_override_in = 1'b1;
    lift_set_in = 16'h0;
    curve_sel_in = `VHZ_CURVE_CONST;
    carrier_sel_in = 3'h1;
    start_mode_in = `VHZ_START_NORMAL;
    stop_mode_in = `VHZ_STOP_COAST;
    remote_in = 1'b0;
    start_cmd_in = 1'b1;
    manual_reset_in = 1'b0;
    fault_in = 1'b0;
    fault_kind_in = `VHZ_FAULT_OTHER;
    target = 16'd600;
    repeat (5) @(posedge sys_clk_in);
    check("run in reset", run_out, 16'h0);
    check("derate in reset", overload_derate_en_out, 16'h1);
    check("restarts in reset", restarts_left_out, 16'h5);
    arst_n_in <= 1'b1;
    wait_for(0, 1'b1, 30000);
    check("settle refused", n >= 19990 && n <= 20010, 16'h1);
    $display("test settle done");
    wait_for(3, 1'b1, 1000);
    repeat (4) @(posedge sys_clk_in);
    check("volt at base", volt_out, 16'd10000);
    target <= 16'd900;
    wait_for(3, 1'b1, 1000);
    repeat (4) @(posedge sys_clk_in);
    check("volt above base", volt_out, 16'd10000);
    target <= 16'd300;
    wait_for(3, 1'b1, 1000);
    repeat (4) @(posedge sys_clk_in);
    check("volt half base", volt_out, 16'd5000);
    lift_set_in <= 16'd400;
    repeat (4) @(posedge sys_clk_in);
    check("lift gone at 30 Hz", volt_out, 16'd5000);
    curve_sel_in <= `VHZ_CURVE_VAR;
    repeat (4) @(posedge sys_clk_in);
    check("variable curve", volt_out, 16'd2500);
    curve_sel_in <= `VHZ_CURVE_CT_NC;
    repeat (4) @(posedge sys_clk_in);
    check("uncomp curve", volt_out, 16'd5000);
    check("uncomp derate", overload_derate_en_out, 16'h0);
    curve_sel_in <= `VHZ_CURVE_CONST;
    for (int s = 1; s <= 5; s++) begin
      carrier_sel_in <= s[2:0];
      repeat (4) @(posedge sys_clk_in);
      check("fixed carrier", carrier_hz_out, 16'd4000 + 16'd2000 * s[15:0]);
    end
    carrier_sel_in <= 3'h0;
    repeat (4) @(posedge sys_clk_in);
    check("carrier 30 Hz", carrier_hz_out, 16'd1800);
    target <= 16'd250;
    wait_for(3, 1'b1, 1000);
    repeat (4) @(posedge sys_clk_in);
    check("carrier 25 Hz", carrier_hz_out, 16'd1500);
    $display("test curve and carrier done");
    start_cmd_in <= 1'b0;
    wait_for(0, 1'b0, 5);
    check("coast stop", n <= 2, 16'h1);
    start_cmd_in <= 1'b1;
    wait_for(0, 1'b1, 5);
    check("coast restart", run_out, 16'h1);
    wait_for(3, 1'b1, 1000);
    stop_mode_in <= `VHZ_STOP_RAMP;
    start_cmd_in <= 1'b0;
    wait_for(0, 1'b0, 1000);
    check("ramp takes time", n >= 250, 16'h1);
    start_cmd_in <= 1'b1;
    wait_for(0, 1'b1, 3000);
    check("ramp hold-off", n >= 1995 && n <= 2015, 16'h1);
    wait_for(3, 1'b1, 1000);
    stop_mode_in <= `VHZ_STOP_RAMP_NOHOLD;
    start_cmd_in <= 1'b0;
    wait_for(0, 1'b0, 1000);
    start_cmd_in <= 1'b1;
    wait_for(0, 1'b1, 3000);
    check("no hold-off", n <= 5, 16'h1);
    $display("test stop modes done");
    wait_for(3, 1'b1, 1000);
    stop_mode_in <= `VHZ_STOP_COAST;
    remote_in <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      start_mode_in <= k ? `VHZ_START_FLY_HIGH : `VHZ_START_FLY_MED;
      pulse_fault(`VHZ_FAULT_OTHER);
      wait_for(2, 1'b1, 10);
      check("waiting shown", restart_waiting_indication_out, 16'h1);
      wait_for(1, 1'b1, 11000);
      repeat (2) @(posedge sys_clk_in);
      check("search used", search_out, 16'h1);
      check("search current", search_current_pct_out, k ? 16'd100 : 16'd50);
      check("search time", search_ms_out, 16'd1000);
      check("restarts left", restarts_left_out, k ? 16'h3 : 16'h4);
      wait_for(1, 1'b0, 11000);
      repeat (4) @(posedge sys_clk_in);
    end
    $display("test flying restart done");
    pulse_fault(`VHZ_FAULT_CONTROL);
    repeat (12000) @(posedge sys_clk_in);
    check("no run after control fault", run_out, 16'h0);
    check("no waiting after control fault", restart_waiting_indication_out, 16'h0);
    $display("test control fault done");
    report_and_stop();
  end
endmodule // tb_vhz_sequencer
`default_nettype wire
